// [hw/ecg_pkg.sv]
// package for the event channel generator select decoder
package ecg_pkg;
    localparam int ECG_NUM_CHANNELS = 10;
    localparam int ECG_CODE_W = 8;
    localparam int ECG_NUM_USART = 6;
    localparam int ECG_NUM_SPI = 2;
    localparam int ECG_NUM_TCA = 2;
    localparam int ECG_NUM_TCB = 5;
    localparam int ECG_NUM_PINS = 8;
    localparam int ECG_NUM_PORTS = 6;
    localparam logic [7:0] ECG_CODE_OFF = 8'h00;
    localparam logic [7:0] ECG_CODE_PIN_BASE = 8'h40;
    localparam logic [7:0] ECG_CODE_PIN_LAST = 8'h4f;
    localparam logic [7:0] ECG_CODE_USART_BASE = 8'h60;
    localparam logic [7:0] ECG_CODE_SPI_BASE = 8'h68;
    localparam logic [7:0] ECG_CODE_TIMER_A_UNIT0_BASE = 8'h80;
    localparam logic [7:0] ECG_CODE_TIMER_A_UNIT1_BASE = 8'h88;
    localparam logic [7:0] ECG_CODE_TCB_BASE = 8'ha0;
    localparam logic [7:0] ECG_CODE_TCD_BASE = 8'hb0;
    // low-order offsets within a timer-a group
    localparam logic [2:0] ECG_TCA_OVF = 3'h0;
    localparam logic [2:0] ECG_TCA_HIGH_BYTE_UNDERFLOW = 3'h1;
    localparam logic [2:0] ECG_TCA_CMP0 = 3'h4;
    localparam logic [2:0] ECG_TCA_CMP1 = 3'h5;
    localparam logic [2:0] ECG_TCA_CMP2 = 3'h6;
    // timer-a event group
    typedef struct packed {
        logic overflow_or_low_underflow;
        logic high_byte_underflow;
        logic compare0_match;
        logic compare1_match;
        logic compare2_match;
    } ecg_tca_ev_t;
    // timer-b event group
    typedef struct packed {
        logic capture_flag_event;
        logic counter_overflow_event;
    } ecg_tcb_ev_t;
    // timer-d event group
    typedef struct packed {
        logic match_b_clear;
        logic match_a_set;
        logic match_b_set;
        logic programmable_event_out;
    } ecg_tcd_ev_t;
    // all generator inputs together
    typedef struct packed {
        logic [ECG_NUM_USART-1:0] serial_port_clock_out;
        logic [ECG_NUM_SPI-1:0] serial_periph_clock_out;
        ecg_tca_ev_t [ECG_NUM_TCA-1:0] timer_a;
        ecg_tcb_ev_t [ECG_NUM_TCB-1:0] timer_b;
        ecg_tcd_ev_t timer_d;
    } ecg_gen_t;
    // state of one channel slice
    typedef struct packed {
        logic [1:0] sel_code_unused;
        logic chan_out;
    } ecg_slice_st_t;
    // state of the top
    typedef struct packed {
        logic [ECG_NUM_CHANNELS-1:0][ECG_CODE_W-1:0] channel_generator_select;
        logic [ECG_NUM_CHANNELS-1:0] chan_out;
    } ecg_top_st_t;
endpackage

// [hw/ecg_decode.sv]
// one channel's combinational generator decoder
`timescale 1ns/100ps
`default_nettype none
module ecg_decode
    import ecg_pkg::*;
#(
    parameter logic [ECG_NUM_USART-1:0] USART_PRESENT = '1,
    parameter logic [ECG_NUM_SPI-1:0] SPI_PRESENT = '1,
    parameter logic [ECG_NUM_TCA-1:0] TCA_PRESENT = '1,
    parameter logic [ECG_NUM_TCB-1:0] TCB_PRESENT = '1,
    parameter logic TCD_PRESENT = 1'b1
) (
    input wire logic [7:0] code,
    input wire ecg_gen_t gen,
    input wire logic [7:0] pin_level,
    output logic sel
);
    // pure mux; the top registers the result
    always_comb begin
        sel = 1'b0; // unassigned or off codes stay low
        for (int i = 0; i < ECG_NUM_USART; i++) begin
            if (code == ECG_CODE_USART_BASE + 8'(i) && USART_PRESENT[i]) begin
                sel = gen.serial_port_clock_out[i];
            end
        end
        for (int i = 0; i < ECG_NUM_SPI; i++) begin
            if (code == ECG_CODE_SPI_BASE + 8'(i) && SPI_PRESENT[i]) begin
                sel = gen.serial_periph_clock_out[i];
            end
        end
        for (int i = 0; i < ECG_NUM_TCA; i++) begin
            // group base by instance
            if (TCA_PRESENT[i] && code[7:3] ==
                (i == 0 ? ECG_CODE_TIMER_A_UNIT0_BASE[7:3] : ECG_CODE_TIMER_A_UNIT1_BASE[7:3]))
            begin
                case (code[2:0])
                    ECG_TCA_OVF: sel = gen.timer_a[i].overflow_or_low_underflow;
                    ECG_TCA_HIGH_BYTE_UNDERFLOW: sel = gen.timer_a[i].high_byte_underflow;
                    ECG_TCA_CMP0: sel = gen.timer_a[i].compare0_match;
                    ECG_TCA_CMP1: sel = gen.timer_a[i].compare1_match;
                    ECG_TCA_CMP2: sel = gen.timer_a[i].compare2_match;
                    default: sel = 1'b0; // gaps in the group
                endcase
            end
        end
        for (int i = 0; i < ECG_NUM_TCB; i++) begin
            // even code capture, odd code overflow
            if (TCB_PRESENT[i] && code == ECG_CODE_TCB_BASE + 8'(2 * i)) begin
                sel = gen.timer_b[i].capture_flag_event;
            end
            if (TCB_PRESENT[i] && code == ECG_CODE_TCB_BASE + 8'(2 * i + 1))
            begin
                sel = gen.timer_b[i].counter_overflow_event;
            end
        end
        if (TCD_PRESENT && code[7:2] == ECG_CODE_TCD_BASE[7:2]) begin
            case (code[1:0])
                2'h0: sel = gen.timer_d.match_b_clear;
                2'h1: sel = gen.timer_d.match_a_set;
                2'h2: sel = gen.timer_d.match_b_set;
                default: sel = gen.timer_d.programmable_event_out;
            endcase
        end
        // pin codes; level already gated by its buffer enable
        if (code >= ECG_CODE_PIN_BASE && code <= ECG_CODE_PIN_LAST) begin
            if (code[3] == 1'b0) begin
                sel = pin_level[code[2:0]];
            end
        end
    end
endmodule
`default_nettype wire

// [hw/ecg_router.sv]
// event channel generator select: channel codes and routed outputs
`timescale 1ns/100ps
`default_nettype none
module ecg_router
    import ecg_pkg::*;
#(
    parameter logic [ECG_NUM_USART-1:0] USART_PRESENT = '1,
    parameter logic [ECG_NUM_SPI-1:0] SPI_PRESENT = '1,
    parameter logic [ECG_NUM_TCA-1:0] TCA_PRESENT = '1,
    parameter logic [ECG_NUM_TCB-1:0] TCB_PRESENT = '1,
    parameter logic TCD_PRESENT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ECG_NUM_CHANNELS-1:0] sel_we,
    input wire logic [7:0] sel_wdata,
    input wire ecg_gen_t gen,
    input wire logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_raw,
    input wire logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_buf_en,
    output logic [ECG_NUM_CHANNELS-1:0][7:0] channel_generator_select,
    output logic [ECG_NUM_CHANNELS-1:0] event_channel
);
    // pin synchroniser stages; stage one feeds stage two only
    logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_s1_reg;
    logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_s2_reg;
    // gated pin levels
    logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_gated;
    // decoder results per channel
    logic [ECG_NUM_CHANNELS-1:0] dec_sel;
    // module state apart from the pin synchroniser stages
    ecg_top_st_t st_reg;
    ecg_top_st_t st_next;

    // two-flop synchroniser for pin levels
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= '0;
            pin_s2_reg <= '0;
        end else begin
            pin_s1_reg <= pin_raw;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    // buffer disabled forces zero
    assign pin_gated = pin_s2_reg & pin_buf_en;

    // one decoder per channel; each channel pair shares one port
    genvar c;
    generate
        for (c = 0; c < ECG_NUM_CHANNELS; c++) begin : g_ch
            logic [7:0] pins;
            // decoder result of this channel, declared before its use
            logic sel_w;
            // channels 2k and 2k+1 see port k on the pin codes
            assign pins = (c / 2 < ECG_NUM_PORTS) ?
                pin_gated[(c / 2 < ECG_NUM_PORTS) ? c / 2 : 0] : 8'h00;
            ecg_decode #(
                .USART_PRESENT(USART_PRESENT),
                .SPI_PRESENT(SPI_PRESENT),
                .TCA_PRESENT(TCA_PRESENT),
                .TCB_PRESENT(TCB_PRESENT),
                .TCD_PRESENT(TCD_PRESENT)
            ) u_dec (
                .code(st_reg.channel_generator_select[c]),
                .gen(gen),
                .pin_level(pins),
                .sel(sel_w)
            );
            assign dec_sel[c] = sel_w;
        end
    endgenerate

    // next state: code writes and registered channel outputs
    always_comb begin
        st_next = st_reg;
        for (int i = 0; i < ECG_NUM_CHANNELS; i++) begin
            if (sel_we[i]) begin
                st_next.channel_generator_select[i] = sel_wdata;
            end
        end
        st_next.chan_out = dec_sel; // at most one source per channel
    end

    // state register; reset turns every channel off
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign channel_generator_select = st_reg.channel_generator_select;
    assign event_channel = st_reg.chan_out;

    // off code keeps the channel low one cycle later
    property p_off_low;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[0] == ECG_CODE_OFF) |=>
            (event_channel[0] == 1'b0);
    endproperty
    a_off_low: assert property (p_off_low) else $error("off ch0 high");

    // serial port 0 clock follows through
    property p_serial_port0;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[0] == ECG_CODE_USART_BASE &&
         USART_PRESENT[0] && $stable(st_reg.channel_generator_select[0]))
        |=> (event_channel[0] == $past(gen.serial_port_clock_out[0]));
    endproperty
    a_serial_port0: assert property (p_serial_port0) else $error("serial_port0 route");

    // spi 1 clock follows through
    property p_spi1;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[1] == ECG_CODE_SPI_BASE + 8'h01 &&
         SPI_PRESENT[1])
        |=> (event_channel[1] == $past(gen.serial_periph_clock_out[1]));
    endproperty
    a_spi1: assert property (p_spi1) else $error("spi1 route");

    // timer-a unit1 high underflow
    property p_timer_a_unit1_high_byte_underflow;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[2] == ECG_CODE_TIMER_A_UNIT1_BASE + 8'h01 &&
         TCA_PRESENT[1])
        |=> (event_channel[2] == $past(gen.timer_a[1].high_byte_underflow));
    endproperty
    a_timer_a_unit1_high_byte_underflow: assert property (p_timer_a_unit1_high_byte_underflow) else $error("timer_a_unit1 high_byte_underflow");

    // timer-a unit0 compare 2
    property p_timer_a_unit0_cmp2;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[3] == ECG_CODE_TIMER_A_UNIT0_BASE + 8'h06 &&
         TCA_PRESENT[0])
        |=> (event_channel[3] == $past(gen.timer_a[0].compare2_match));
    endproperty
    a_timer_a_unit0_cmp2: assert property (p_timer_a_unit0_cmp2) else $error("timer_a_unit0 cmp2");

    // timer-b unit4 overflow on odd code
    property p_tcb4_ovf;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[4] == ECG_CODE_TCB_BASE + 8'h09 &&
         TCB_PRESENT[4])
        |=> (event_channel[4] == $past(gen.timer_b[4].counter_overflow_event));
    endproperty
    a_tcb4_ovf: assert property (p_tcb4_ovf) else $error("tcb4 ovf");

    // timer-d programmable event
    property p_tcd_prog;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[5] == ECG_CODE_TCD_BASE + 8'h03 &&
         TCD_PRESENT)
        |=> (event_channel[5] == $past(gen.timer_d.programmable_event_out));
    endproperty
    a_tcd_prog: assert property (p_tcd_prog) else $error("tcd prog");

    // disabled pin buffer reads zero
    property p_pin_gate;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[0] == ECG_CODE_PIN_BASE &&
         !pin_buf_en[0][0]) |=> (event_channel[0] == 1'b0);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("pin gate");

    // unassigned code stays low
    property p_unassigned;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[6] == 8'hff) |=>
            (event_channel[6] == 1'b0);
    endproperty
    a_unassigned: assert property (p_unassigned) else $error("code ff");

    // a written code shows on the register one cycle later
    property p_code_load;
        @(posedge clk) disable iff (rst)
        sel_we[0] |=> (channel_generator_select[0] == $past(sel_wdata));
    endproperty
    a_code_load: assert property (p_code_load) else $error("load");

    // timer-a unit0 overflow on its base code
    property p_timer_a_unit0_ovf;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[8] == ECG_CODE_TIMER_A_UNIT0_BASE &&
         TCA_PRESENT[0])
        |=> (event_channel[8] ==
            $past(gen.timer_a[0].overflow_or_low_underflow));
    endproperty
    a_timer_a_unit0_ovf: assert property (p_timer_a_unit0_ovf) else $error("timer_a_unit0 ovf");

    // timer-b unit0 capture follows the capture flag event
    property p_timer_b_unit0_capture_flag_event;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[8] == ECG_CODE_TCB_BASE &&
         TCB_PRESENT[0])
        |=> (event_channel[8] ==
            $past(gen.timer_b[0].capture_flag_event));
    endproperty
    a_timer_b_unit0_capture_flag_event: assert property (p_timer_b_unit0_capture_flag_event) else $error("timer_b_unit0 capture_flag_event");

    // missing timer-d leaves its codes dark
    property p_absent_tcd;
        @(posedge clk) disable iff (rst)
        (!TCD_PRESENT &&
         st_reg.channel_generator_select[5][7:2] == ECG_CODE_TCD_BASE[7:2])
        |=> (event_channel[5] == 1'b0);
    endproperty
    a_absent_tcd: assert property (p_absent_tcd) else $error("tcd");

    // channel 2 sees port 1; a disabled buffer reads zero there too
    property p_pin_port1;
        @(posedge clk) disable iff (rst)
        (st_reg.channel_generator_select[2] == ECG_CODE_PIN_BASE + 8'h03 &&
         !pin_buf_en[1][3]) |=> (event_channel[2] == 1'b0);
    endproperty
    a_pin_port1: assert property (p_pin_port1) else $error("pin p1");
endmodule
`default_nettype wire

// [verif/ecg_gen_model.sv]
// behavioural model of the peripheral event generators
`timescale 1ns/100ps
`default_nettype none
module ecg_gen_model
    import ecg_pkg::*;
(
    input wire logic clk,
    input wire logic [7:0] fire,
    input wire logic invert,
    output ecg_gen_t gen
);
    ecg_gen_t g; // pattern before optional inversion
    // one generator high, or all but it when inverted
    always_comb begin
        g = '0;
        if (fire >= 8'h60 && fire <= 8'h65) begin
            g.serial_port_clock_out[fire[2:0]] = 1'b1;
        end else if (fire == 8'h68 || fire == 8'h69) begin
            g.serial_periph_clock_out[fire[0]] = 1'b1;
        end else if (fire[7:4] == 4'h8) begin
            case (fire[2:0])
                3'h0: g.timer_a[fire[3]].overflow_or_low_underflow = 1'b1;
                3'h1: g.timer_a[fire[3]].high_byte_underflow = 1'b1;
                3'h4: g.timer_a[fire[3]].compare0_match = 1'b1;
                3'h5: g.timer_a[fire[3]].compare1_match = 1'b1;
                3'h6: g.timer_a[fire[3]].compare2_match = 1'b1;
                default: g = '0;
            endcase
        end else if (fire >= 8'ha0 && fire <= 8'ha9) begin
            // even code drives capture, odd code drives overflow
            if (fire[0]) begin
                g.timer_b[(fire - 8'ha0) >> 1].counter_overflow_event = 1'b1;
            end else begin
                g.timer_b[(fire - 8'ha0) >> 1].capture_flag_event = 1'b1;
            end
        end else if (fire >= 8'hb0 && fire <= 8'hb3) begin
            case (fire[1:0])
                2'h0: g.timer_d.match_b_clear = 1'b1;
                2'h1: g.timer_d.match_a_set = 1'b1;
                2'h2: g.timer_d.match_b_set = 1'b1;
                default: g.timer_d.programmable_event_out = 1'b1;
            endcase
        end
    end
    // registered, so routes see the pattern one edge after fire
    always_ff @(posedge clk) begin
        gen <= invert ? ~g : g;
    end
endmodule
`default_nettype wire

// [verif/test_event_channel_generator_select.sv]
// self-checking bench for the generator select router
`timescale 1ns/100ps
`default_nettype none
module test_event_channel_generator_select;
    import ecg_pkg::*;
    logic clk, rst, invert;
    logic [ECG_NUM_CHANNELS-1:0] sel_we;
    logic [7:0] sel_wdata, fire;
    ecg_gen_t gen;
    logic [ECG_NUM_PORTS-1:0][ECG_NUM_PINS-1:0] pin_raw, pin_buf_en;
    logic [ECG_NUM_CHANNELS-1:0][7:0] code_full, code_small;
    logic [ECG_NUM_CHANNELS-1:0] ev_full, ev_small;
    int bad_count, compares;
    ecg_gen_model ecg_gen_model_i (.clk(clk), .fire(fire),
        .invert(invert), .gen(gen));
    // full variant with every instance present
    ecg_router ecg_router_i (.clk(clk), .rst(rst), .sel_we(sel_we),
        .sel_wdata(sel_wdata), .gen(gen), .pin_raw(pin_raw),
        .pin_buf_en(pin_buf_en), .channel_generator_select(code_full),
        .event_channel(ev_full));
    // small pin-count variant, upper instances missing
    ecg_router #(.USART_PRESENT(6'h07), .SPI_PRESENT(2'h1),
        .TCA_PRESENT(2'h1), .TCB_PRESENT(5'h07), .TCD_PRESENT(1'b0))
        small_i (.clk(clk), .rst(rst), .sel_we(sel_we),
        .sel_wdata(sel_wdata), .gen(gen), .pin_raw(pin_raw),
        .pin_buf_en(pin_buf_en), .channel_generator_select(code_small),
        .event_channel(ev_small));
    // free-running clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic finish_test();
        if (bad_count == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            #1;
        end
    endtask
    // one-cycle write strobe, then settle past the latency
    task automatic write_code(input int ch, input logic [7:0] code);
        sel_we = '0;
        sel_we[ch] = 1'b1;
        sel_wdata = code;
        tick(1);
        sel_we = '0;
        tick(5);
    endtask
    task automatic test_reset();
        for (int c = 0; c < ECG_NUM_CHANNELS; c++) begin
            check(code_full[c], 8'h00);
            check({7'h0, ev_full[c]}, 8'h00);
        end
    endtask
    // every generator code, high alone then low among all others high
    task automatic test_routes();
        logic [7:0] codes[35];
        codes = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'h65, 8'h68,
            8'h69, 8'h80, 8'h81, 8'h84, 8'h85, 8'h86, 8'h88, 8'h89,
            8'h8c, 8'h8d, 8'h8e, 8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4,
            8'ha5, 8'ha6, 8'ha7, 8'ha8, 8'ha9, 8'hb0, 8'hb1, 8'hb2,
            8'hb3, 8'h60, 8'h8c, 8'hb3};
        foreach (codes[i]) begin
            fire = codes[i];
            invert = 1'b0;
            write_code(i % 10, codes[i]);
            check(code_full[i % 10], codes[i]);
            check({7'h0, ev_full[i % 10]}, 8'h01);
            invert = 1'b1;
            tick(4);
            check({7'h0, ev_full[i % 10]}, 8'h00);
        end
    endtask
    // unassigned codes and the off code stay low with all sources high
    task automatic test_unassigned();
        logic [7:0] codes[9];
        codes = '{8'h66, 8'h6a, 8'h82, 8'h87, 8'h8f, 8'haa, 8'hb4,
            8'hff, 8'h00};
        fire = 8'h00;
        invert = 1'b1;
        foreach (codes[i]) begin
            write_code(3, codes[i]);
            check({7'h0, ev_full[3]}, 8'h00);
        end
    endtask
    // port 1 pin 3 seen by channel 2, gated by its input buffer
    task automatic test_pins();
        pin_raw[1][3] = 1'b1;
        write_code(2, 8'h43);
        check({7'h0, ev_full[2]}, 8'h01);
        pin_buf_en[1][3] = 1'b0;
        tick(5);
        check({7'h0, ev_full[2]}, 8'h00);
        pin_buf_en[1][3] = 1'b1;
        pin_raw[1][3] = 1'b0;
    endtask
    // absent instances give nothing on the small variant
    task automatic test_absent();
        logic [7:0] codes[6];
        codes = '{8'h88, 8'ha8, 8'h63, 8'h69, 8'hb0, 8'ha4};
        invert = 1'b0;
        foreach (codes[i]) begin
            fire = codes[i];
            write_code(5, codes[i]);
            check({7'h0, ev_full[5]}, 8'h01);
            check({7'h0, ev_small[5]}, {7'h0, i == 5});
            check(code_small[5], codes[i]);
        end
    endtask
    // channels and codes that the design's own assertions watch
    task automatic test_watched();
        int chans[5];
        logic [7:0] codes[5];
        chans = '{1, 2, 3, 4, 5};
        codes = '{8'h69, 8'h89, 8'h86, 8'ha9, 8'hb3};
        foreach (codes[i]) begin
            fire = codes[i];
            invert = 1'b0;
            write_code(chans[i], codes[i]);
            check({7'h0, ev_full[chans[i]]}, 8'h01);
            invert = 1'b1;
            tick(4);
            check({7'h0, ev_full[chans[i]]}, 8'h00);
        end
        write_code(6, 8'hff);
        check({7'h0, ev_full[6]}, 8'h00);
        pin_raw[0][0] = 1'b1;
        pin_buf_en[0][0] = 1'b0;
        write_code(0, 8'h40);
        check({7'h0, ev_full[0]}, 8'h00);
        pin_buf_en[0][0] = 1'b1;
        tick(3);
        check({7'h0, ev_full[0]}, 8'h01);
        pin_raw[0][0] = 1'b0;
    endtask
    // watchdog against a hang
    initial begin
        #50000;
        bad_count++;
        finish_test();
    end
    // main sequence
    initial begin
        bad_count = 0;
        compares = 0;
        rst = 1'b1;
        sel_we = '0;
        sel_wdata = 8'h00;
        fire = 8'h00;
        invert = 1'b0;
        pin_raw = '0;
        pin_buf_en = '1;
        tick(10);
        test_reset();
        rst = 1'b0;
        tick(1);
        test_reset();
        test_routes();
        test_unassigned();
        test_pins();
        test_absent();
        test_watched();
        finish_test();
    end
endmodule
`default_nettype wire
